// [common/pcip_pkg.sv]
// Constants for the port change detection and pull-up block
package pcip_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;
  // Register offsets
  localparam logic [3:0]  OFF_PA_DATA   = 4'h0;
  localparam logic [3:0]  OFF_PB_DATA   = 4'h1;
  localparam logic [3:0]  OFF_PA_DIR    = 4'h2;
  localparam logic [3:0]  OFF_PB_DIR    = 4'h3;
  localparam logic [3:0]  OFF_PB_PULLUP = 4'h4;
  localparam logic [3:0]  OFF_PB_ANSEL  = 4'h5;
  localparam logic [3:0]  OFF_PA_CHG_EN = 4'h6;
  localparam logic [3:0]  OFF_PB_CHG_EN = 4'h7;
  localparam logic [3:0]  OFF_CORE_INT  = 4'h8;
  localparam logic [3:0]  OFF_OPTION    = 4'h9;
  // Implemented bit masks
  localparam logic [7:0]  PA_MASK       = 8'hEF;
  localparam logic [7:0]  PB_MASK       = 8'hF3;
  localparam logic [7:0]  PULLUP_MASK   = 8'hF2;
  localparam logic [7:0]  ANSEL_MASK    = 8'h72;
  localparam logic [7:0]  PA_CHG_MASK   = 8'hEF;
  localparam logic [7:0]  PB_CHG_MASK   = 8'hF3;
  // Reset values
  localparam logic [7:0]  PULLUP_RST    = 8'hF2;
  localparam logic [7:0]  ANSEL_RST     = 8'h72;
  localparam logic [7:0]  CHG_EN_RST    = 8'h00;
  localparam logic [7:0]  PA_DIR_RST    = 8'hEF;
  localparam logic [7:0]  PB_DIR_RST    = 8'hF3;
  localparam logic [7:0]  ZERO8         = 8'h00;
  // Field positions
  localparam int          FLAG_BIT      = 0;
  localparam int          IRQ_EN_BIT    = 3;
  localparam int          GPU_BIT       = 7;
  localparam int          PA_RST_PIN    = 5;
endpackage : pcip_pkg

// [design/pcip_top.sv]
// Port change detection, port B pull-up and analog select logic
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps

// Notes on behaviour
// - Pull-up on only if global enable, input direction, own bit set, not analog.
// - Pull-up register implements bits 7..4 and 1, reset to 1; others read 0.
// - Analog select implements bits 6..4 and 1, reset to 1; 1 means analog.
// - Analog pin loses digital input, pull-up and change detection.
// - All change enables are 0 after power-on reset.
// - Port A pin 5 detection is off while it serves as reset input.
// - Enabled pins compared with last-read latch; mismatches ORed into the flag.
// - Interrupt enable gates only the request; detection keeps running.
// - Port A change enables implement bits 7..5 and 3..0; bit 4 reads 0.
// - Port B change enables implement bits 7..4 and 1..0; bits 3..2 read 0.
// - A persisting mismatch keeps setting the flag.
// - Last-read latch survives external reset; mismatch sets flag again.
// - A change coinciding with a port access still sets the flag.
// - Change event wakes the device when interrupt enable is set.
// - Flag is bit 0, interrupt enable bit 3 of core interrupt control.
// - Digital read of an analog pin returns zero.
module pcip_top #(
  parameter int ADDR_W = pcip_pkg::ADDR_W,
  parameter int DATA_W = pcip_pkg::DATA_W
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  input  wire logic              EXT_RST,
  input  wire logic              PA5_IS_RESET,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  input  wire logic [7:0]        PA_IN,
  output logic      [7:0]        PA_OUT,
  output logic      [7:0]        PA_OE,
  input  wire logic [7:0]        PB_IN,
  output logic      [7:0]        PB_OUT,
  output logic      [7:0]        PB_OE,
  output logic      [7:0]        PB_PULLUP,
  output logic                   CHANGE_IRQ
);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
  logic [7:0] pa_last_q, pb_last_q;
  logic [7:0] pa_lat_q, pb_lat_q, pa_dir_q, pb_dir_q;
  logic [7:0] pullup_q, ansel_q, pa_chg_q, pb_chg_q;
  logic       gpu_q, flag_q, irq_en_q;
  logic [7:0] pa_val, pb_val, pa_mism, pb_mism, pa_en, pb_en;
  logic       any_mism, port_acc, flag_d;

  // Two stages per pin; only the second stage is looked at
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pa_s1_q <= pcip_pkg::ZERO8;
      pa_s2_q <= pcip_pkg::ZERO8;
      pb_s1_q <= pcip_pkg::ZERO8;
      pb_s2_q <= pcip_pkg::ZERO8;
    end else begin
      pa_s1_q <= PA_IN;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= PB_IN;
      pb_s2_q <= pb_s1_q;
    end
  end

  // Digital view of the pins; analog pins read as zero
  assign pa_val = pa_s2_q & pcip_pkg::PA_MASK;
  assign pb_val = pb_s2_q & pcip_pkg::PB_MASK & ~ansel_q;

  // Detection enables: pin 5 of port A drops out in reset mode
  always_comb begin
    pa_en = pa_chg_q & pcip_pkg::PA_CHG_MASK;
    if (PA5_IS_RESET) begin
      pa_en[pcip_pkg::PA_RST_PIN] = 1'b0;
    end
    pb_en = pb_chg_q & pcip_pkg::PB_CHG_MASK & ~ansel_q;
  end

  assign pa_mism  = pa_en & (pa_val ^ pa_last_q);
  assign pb_mism  = pb_en & (pb_val ^ pb_last_q);
  assign any_mism = |{pa_mism, pb_mism};

  assign port_acc = (RD | WR) & (hit(ADDR, pcip_pkg::OFF_PA_DATA) | hit(ADDR, pcip_pkg::OFF_PB_DATA));

  // Latch of last-read values: cleared only at power-on, not by the pin reset.
  // Any port access captures both ports; a change landing in that cycle still
  // mismatches the old latch value and sets the flag.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pa_last_q <= pcip_pkg::ZERO8;
      pb_last_q <= pcip_pkg::ZERO8;
    end else if (port_acc) begin
      pa_last_q <= pa_val;
      pb_last_q <= pb_val;
    end
  end

  // Shared change flag: hardware set outranks the software clear
  always_comb begin
    flag_d = flag_q;
    if (WR && hit(ADDR, pcip_pkg::OFF_CORE_INT)) begin
      flag_d = WDATA[pcip_pkg::FLAG_BIT] & flag_q;
    end
    if (EXT_RST) begin
      flag_d = 1'b0;
    end
    if (any_mism) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Configuration registers; the pin reset restores them like power-on, except the port A and B output latches
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pullup_q <= pcip_pkg::PULLUP_RST;
      ansel_q  <= pcip_pkg::ANSEL_RST;
      pa_chg_q <= pcip_pkg::CHG_EN_RST;
      pb_chg_q <= pcip_pkg::CHG_EN_RST;
      pa_dir_q <= pcip_pkg::PA_DIR_RST;
      pb_dir_q <= pcip_pkg::PB_DIR_RST;
      pa_lat_q <= pcip_pkg::ZERO8;
      pb_lat_q <= pcip_pkg::ZERO8;
      gpu_q    <= 1'b0;
      irq_en_q <= 1'b0;
    end else if (EXT_RST) begin
      pullup_q <= pcip_pkg::PULLUP_RST;
      ansel_q  <= pcip_pkg::ANSEL_RST;
      pa_chg_q <= pcip_pkg::CHG_EN_RST;
      pb_chg_q <= pcip_pkg::CHG_EN_RST;
      pa_dir_q <= pcip_pkg::PA_DIR_RST;
      pb_dir_q <= pcip_pkg::PB_DIR_RST;
      gpu_q    <= 1'b0;
      irq_en_q <= 1'b0;
    end else if (WR) begin
      if (hit(ADDR, pcip_pkg::OFF_PB_PULLUP)) pullup_q <= WDATA & pcip_pkg::PULLUP_MASK;
      if (hit(ADDR, pcip_pkg::OFF_PB_ANSEL))  ansel_q  <= WDATA & pcip_pkg::ANSEL_MASK;
      if (hit(ADDR, pcip_pkg::OFF_PA_CHG_EN)) pa_chg_q <= WDATA & pcip_pkg::PA_CHG_MASK;
      if (hit(ADDR, pcip_pkg::OFF_PB_CHG_EN)) pb_chg_q <= WDATA & pcip_pkg::PB_CHG_MASK;
      if (hit(ADDR, pcip_pkg::OFF_PA_DIR))    pa_dir_q <= WDATA & pcip_pkg::PA_MASK;
      if (hit(ADDR, pcip_pkg::OFF_PB_DIR))    pb_dir_q <= WDATA & pcip_pkg::PB_MASK;
      if (hit(ADDR, pcip_pkg::OFF_PA_DATA))   pa_lat_q <= WDATA & pcip_pkg::PA_MASK;
      if (hit(ADDR, pcip_pkg::OFF_PB_DATA))   pb_lat_q <= WDATA & pcip_pkg::PB_MASK;
      if (hit(ADDR, pcip_pkg::OFF_OPTION))    gpu_q    <= WDATA[pcip_pkg::GPU_BIT];
      if (hit(ADDR, pcip_pkg::OFF_CORE_INT))  irq_en_q <= WDATA[pcip_pkg::IRQ_EN_BIT];
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= pcip_pkg::ZERO8;
    end else if (RD) begin
      RDATA <= pcip_pkg::ZERO8;
      unique case (1'b1)
        hit(ADDR, pcip_pkg::OFF_PA_DATA):   RDATA <= pa_val;
        hit(ADDR, pcip_pkg::OFF_PB_DATA):   RDATA <= pb_val;
        hit(ADDR, pcip_pkg::OFF_PA_DIR):    RDATA <= pa_dir_q;
        hit(ADDR, pcip_pkg::OFF_PB_DIR):    RDATA <= pb_dir_q;
        hit(ADDR, pcip_pkg::OFF_PB_PULLUP): RDATA <= pullup_q;
        hit(ADDR, pcip_pkg::OFF_PB_ANSEL):  RDATA <= ansel_q;
        hit(ADDR, pcip_pkg::OFF_PA_CHG_EN): RDATA <= pa_chg_q;
        hit(ADDR, pcip_pkg::OFF_PB_CHG_EN): RDATA <= pb_chg_q;
        hit(ADDR, pcip_pkg::OFF_OPTION):    RDATA[pcip_pkg::GPU_BIT] <= gpu_q;
        hit(ADDR, pcip_pkg::OFF_CORE_INT): begin
          RDATA[pcip_pkg::FLAG_BIT]   <= flag_q;
          RDATA[pcip_pkg::IRQ_EN_BIT] <= irq_en_q;
        end
        default: RDATA <= pcip_pkg::ZERO8;
      endcase
    end else begin
      RDATA <= pcip_pkg::ZERO8;
    end
  end

  // Pin drivers, pull-ups and the request; analog select masks only the pull-ups
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PA_OUT     <= pcip_pkg::ZERO8;
      PA_OE      <= pcip_pkg::ZERO8;
      PB_OUT     <= pcip_pkg::ZERO8;
      PB_OE      <= pcip_pkg::ZERO8;
      PB_PULLUP  <= pcip_pkg::ZERO8;
      CHANGE_IRQ <= 1'b0;
    end else begin
      PA_OUT     <= pa_lat_q;
      PA_OE      <= ~pa_dir_q & pcip_pkg::PA_MASK;
      PB_OUT     <= pb_lat_q;
      PB_OE      <= ~pb_dir_q & pcip_pkg::PB_MASK;
      PB_PULLUP  <= {8{gpu_q}} & pb_dir_q & pullup_q & ~ansel_q;
      CHANGE_IRQ <= flag_q & irq_en_q;
    end
  end

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence port_rd_s;
    RD && hit(ADDR, pcip_pkg::OFF_PB_DATA);
  endsequence
  sequence flag_clr_s;
    WR && hit(ADDR, pcip_pkg::OFF_CORE_INT) && !WDATA[pcip_pkg::FLAG_BIT] && !any_mism;
  endsequence
  sequence core_wr_s;
    WR && hit(ADDR, pcip_pkg::OFF_CORE_INT);
  endsequence
  sequence core_rd_s;
    RD && hit(ADDR, pcip_pkg::OFF_CORE_INT);
  endsequence
  sequence pa_rd_s;
    RD && hit(ADDR, pcip_pkg::OFF_PA_DATA);
  endsequence
  sequence ansel_rd_s;
    RD && hit(ADDR, pcip_pkg::OFF_PB_ANSEL);
  endsequence
  sequence pachg_rd_s;
    RD && hit(ADDR, pcip_pkg::OFF_PA_CHG_EN);
  endsequence
  sequence pbchg_rd_s;
    RD && hit(ADDR, pcip_pkg::OFF_PB_CHG_EN);
  endsequence

  flag_set_a: assert property (any_mism |=> flag_q)
    else $error("mismatch did not set flag");
  flag_clear_a: assert property (flag_clr_s |=> !flag_q)
    else $error("flag clear ignored");
  irq_gate_a: assert property (CHANGE_IRQ |-> $past(flag_q) && $past(irq_en_q))
    else $error("request without flag and enable");
  irq_raise_a: assert property (flag_q && irq_en_q |=> CHANGE_IRQ)
    else $error("request missing");
  analog_read_a: assert property (port_rd_s |=> (RDATA & $past(ansel_q)) == pcip_pkg::ZERO8)
    else $error("analog pin read nonzero");
  latch_capture_a: assert property (port_rd_s |=> pb_last_q == $past(pb_val))
    else $error("latch not captured");
  latch_keep_a: assert property (EXT_RST && !port_acc |=> $stable(pa_last_q) && $stable(pb_last_q))
    else $error("latch lost on pin reset");
  pin5_off_a: assert property (PA5_IS_RESET |-> !pa_mism[pcip_pkg::PA_RST_PIN])
    else $error("pin 5 detected in reset mode");
  analog_chg_a: assert property ((pb_mism & ansel_q) == pcip_pkg::ZERO8)
    else $error("analog pin detected");
  pullup_a: assert property (##1 PB_PULLUP == ($past(pullup_q & pb_dir_q & ~ansel_q) & {8{$past(gpu_q)}}))
    else $error("pull-up wrong");
  unimpl_a: assert property (RD && hit(ADDR, pcip_pkg::OFF_PB_PULLUP) |=> (RDATA & ~pcip_pkg::PULLUP_MASK) == pcip_pkg::ZERO8)
    else $error("unimplemented pull-up bits");

  // Pull-up gating: a missing input direction, global enable or analog clear must drop the pull-up
  pullup_dir_a: assert property (##1 (PB_PULLUP & ~$past(pb_dir_q)) == pcip_pkg::ZERO8)
    else $error("pull-up on an output pin");
  pullup_gpu_a: assert property (!gpu_q |=> PB_PULLUP == pcip_pkg::ZERO8)
    else $error("pull-up without global enable");
  analog_pull_a: assert property (##1 (PB_PULLUP & $past(ansel_q)) == pcip_pkg::ZERO8)
    else $error("pull-up on an analog pin");

  // Analog pins lose their digital path and their detection; port A pin 5 in reset mode loses only its detection
  analog_val_a: assert property ((pb_val & ansel_q) == pcip_pkg::ZERO8)
    else $error("analog pin has a digital value");
  pb_chg_analog_a: assert property ((pb_en & ansel_q) == pcip_pkg::ZERO8)
    else $error("analog pin enabled for detection");
  pin5_en_a: assert property (PA5_IS_RESET |-> !pa_en[pcip_pkg::PA_RST_PIN])
    else $error("pin 5 enabled in reset mode");

  // Implemented bits only, in the registers and in the enables
  pa_en_bits_a: assert property ((pa_en & ~pcip_pkg::PA_CHG_MASK) == pcip_pkg::ZERO8)
    else $error("port A enable on missing bit");
  pb_en_bits_a: assert property ((pb_en & ~pcip_pkg::PB_CHG_MASK) == pcip_pkg::ZERO8)
    else $error("port B enable on missing bit");
  pullup_mask_a: assert property ((pullup_q & ~pcip_pkg::PULLUP_MASK) == pcip_pkg::ZERO8)
    else $error("pull-up register holds missing bit");
  ansel_mask_a: assert property ((ansel_q & ~pcip_pkg::ANSEL_MASK) == pcip_pkg::ZERO8)
    else $error("analog register holds missing bit");
  ansel_unimpl_a: assert property (ansel_rd_s |=> (RDATA & ~pcip_pkg::ANSEL_MASK) == pcip_pkg::ZERO8)
    else $error("unimplemented analog bits");
  pa_chg_unimpl_a: assert property (pachg_rd_s |=> (RDATA & ~pcip_pkg::PA_CHG_MASK) == pcip_pkg::ZERO8)
    else $error("unimplemented port A enable bits");
  pb_chg_unimpl_a: assert property (pbchg_rd_s |=> (RDATA & ~pcip_pkg::PB_CHG_MASK) == pcip_pkg::ZERO8)
    else $error("unimplemented port B enable bits");

  // Pin reset brings configuration back but leaves the latch alone
  chg_rst_a: assert property (EXT_RST |=> pa_chg_q == pcip_pkg::CHG_EN_RST && pb_chg_q == pcip_pkg::CHG_EN_RST)
    else $error("change enables survive pin reset");
  pullup_rst_a: assert property (EXT_RST |=> pullup_q == pcip_pkg::PULLUP_RST)
    else $error("pull-up register not restored");
  ansel_rst_a: assert property (EXT_RST |=> ansel_q == pcip_pkg::ANSEL_RST)
    else $error("analog register not restored");
  ext_mism_a: assert property (EXT_RST && any_mism |=> flag_q)
    else $error("mismatch lost across pin reset");
  latch_idle_a: assert property (!port_acc |=> $stable(pa_last_q) && $stable(pb_last_q))
    else $error("latch moved without port access");

  // Flag: only hardware sets it, and a live mismatch beats the clear
  flag_origin_a: assert property ($rose(flag_q) |-> $past(any_mism))
    else $error("flag set without mismatch");
  flag_hold_a: assert property (flag_q && !EXT_RST && !(WR && hit(ADDR, pcip_pkg::OFF_CORE_INT)) |=> flag_q)
    else $error("flag dropped by itself");
  flag_one_a: assert property (core_wr_s ##0 (WDATA[pcip_pkg::FLAG_BIT] && !flag_q && !any_mism) |=> !flag_q)
    else $error("software set the flag");
  clr_blocked_a: assert property (core_wr_s ##0 any_mism |=> flag_q)
    else $error("clear won over mismatch");
  capture_both_a: assert property (port_acc |=> pa_last_q == $past(pa_val) && pb_last_q == $past(pb_val))
    else $error("port access missed a latch");

  // Request and wake-up follow flag and enable
  irq_mask_a: assert property (!irq_en_q |=> !CHANGE_IRQ)
    else $error("request while disabled");
  irq_fall_a: assert property (!flag_q |=> !CHANGE_IRQ)
    else $error("request without flag");
  irq_wake_a: assert property ($rose(CHANGE_IRQ) |-> $past(flag_q) && $past(irq_en_q))
    else $error("wake without cause");
  irq_en_write_a: assert property (core_wr_s ##0 !EXT_RST |=> irq_en_q == $past(WDATA[pcip_pkg::IRQ_EN_BIT]))
    else $error("interrupt enable not written");
  core_read_a: assert property (core_rd_s |=> RDATA[pcip_pkg::FLAG_BIT] == $past(flag_q)
                                && RDATA[pcip_pkg::IRQ_EN_BIT] == $past(irq_en_q))
    else $error("core control read wrong");

  // Pins reach the comparison only through both stages
  pa_sync_a: assert property (##2 pa_s2_q == $past(PA_IN, 2))
    else $error("port A synchroniser depth");
  pb_sync_a: assert property (##2 pb_s2_q == $past(PB_IN, 2))
    else $error("port B synchroniser depth");
  pa_read_a: assert property (pa_rd_s |=> RDATA == $past(pa_val))
    else $error("port A read wrong");
  pb_read_a: assert property (port_rd_s |=> RDATA == $past(pb_val))
    else $error("port B read wrong");

endmodule : pcip_top

// [bench/port_change_interrupt_pullups_test.sv]
// Self-checking bench for the port change detection and pull-up block
`timescale 1ns/100ps
module port_change_interrupt_pullups_test;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ext_rst = 1'b0;
  logic       pa5_rst = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] pa_in = 8'h00;
  logic [7:0] pb_in = 8'h00;
  logic [7:0] rdata;
  logic [7:0] pb_pullup;
  logic [7:0] pa_out;
  logic [7:0] pa_oe;
  logic [7:0] pb_out;
  logic [7:0] pb_oe;
  logic       change_irq;
  int         err_total = 0;
  int         compares = 0;

  always #10 sys_clk = ~sys_clk;

  pcip_top pcip_top_inst (.SYS_CLK(sys_clk), .RST(rst), .EXT_RST(ext_rst), .PA5_IS_RESET(pa5_rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in),
    .PB_OUT(pb_out), .PB_OE(pb_oe), .PB_PULLUP(pb_pullup), .CHANGE_IRQ(change_irq));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      #1;
      if (change_irq === exp) return;
    end
    chk({7'h00, change_irq}, {7'h00, exp});
    conclude();
  endtask : wait_irq

  task automatic reg_map;
    rd_chk(4'h4, pcip_pkg::PULLUP_RST);
    rd_chk(4'h5, pcip_pkg::ANSEL_RST);
    rd_chk(4'h6, 8'h00);
    rd_chk(4'h7, 8'h00);
    rd_chk(4'hF, 8'h00);
    for (int a = 4; a < 9; a++) wr_reg(a[3:0], 8'hFF);
    rd_chk(4'h4, 8'hF2);
    rd_chk(4'h5, 8'h72);
    rd_chk(4'h6, 8'hEF);
    rd_chk(4'h7, 8'hF3);
    rd_chk(4'h8, 8'h08);
    wr_reg(4'h8, 8'h00);
  endtask : reg_map

  task automatic pullups;
    wr_reg(4'h9, 8'h80);
    wr_reg(4'h5, 8'h00);
    idle(2);
    chk(pb_pullup, 8'hF2);
    wr_reg(4'h5, 8'h70);
    pb_in <= 8'h12;
    idle(4);
    chk(pb_pullup, 8'h82);
    rd_chk(4'h1, 8'h02);
    wr_reg(4'h3, 8'h73);
    idle(2);
    chk(pb_pullup, 8'h02);
    wr_reg(4'h9, 8'h00);
    idle(2);
    chk(pb_pullup, 8'h00);
  endtask : pullups

  task automatic change_flow;
    wr_reg(4'h5, 8'h00);
    wr_reg(4'h3, 8'hF3);
    wr_reg(4'h6, 8'h00);
    wr_reg(4'h7, 8'h02);
    pb_in <= 8'h00;
    idle(4);
    rd_chk(4'h1, 8'h00);
    wr_reg(4'h8, 8'h08);
    pb_in <= 8'h02;
    wait_irq(1'b1);
    rd_chk(4'h8, 8'h09);
    wr_reg(4'h8, 8'h08);
    idle(2);
    rd_chk(4'h8, 8'h09);
    rd_chk(4'h1, 8'h02);
    wr_reg(4'h8, 8'h08);
    wait_irq(1'b0);
    wr_reg(4'h8, 8'h00);
    pb_in <= 8'h00;
    idle(4);
    rd_chk(4'h8, 8'h01);
    chk({7'h00, change_irq}, 8'h00);
    wr_reg(4'h7, 8'h00);
    rd_chk(4'h1, 8'h00);
    wr_reg(4'h8, 8'h00);
  endtask : change_flow

  task automatic pin_five;
    pa5_rst <= 1'b1;
    wr_reg(4'h6, 8'h20);
    pa_in <= 8'h20;
    idle(5);
    rd_chk(4'h8, 8'h00);
    pa5_rst <= 1'b0;
    idle(4);
    rd_chk(4'h8, 8'h01);
    rd_chk(4'h0, 8'h20);
    wr_reg(4'h8, 8'h00);
    rd_chk(4'h8, 8'h00);
  endtask : pin_five

  // Latch must keep the old pin value across the external reset
  task automatic ext_reset;
    wr_reg(4'h6, 8'h00);
    pb_in <= 8'h02;
    idle(4);
    rd_chk(4'h1, 8'h02);
    @(posedge sys_clk);
    pb_in <= 8'h00;
    idle(4);
    ext_rst <= 1'b1;
    @(posedge sys_clk);
    ext_rst <= 1'b0;
    rd_chk(4'h5, pcip_pkg::ANSEL_RST);
    wr_reg(4'h5, 8'h00);
    wr_reg(4'h7, 8'h02);
    idle(4);
    rd_chk(4'h8, 8'h01);
  endtask : ext_reset

  // Analog pins kept as inputs; analog select leaves the drivers alone
  task automatic drivers;
    wr_reg(4'h5, 8'h72);
    wr_reg(4'h3, 8'h72);
    wr_reg(4'h1, 8'hFF);
    wr_reg(4'h2, 8'h0F);
    wr_reg(4'h0, 8'hFF);
    idle(2);
    chk(pb_oe, 8'h81);
    chk(pb_out, 8'hF3);
    chk(pa_oe, 8'hE0);
    chk(pa_out, 8'hEF);
  endtask : drivers

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    reg_map();
    pullups();
    change_flow();
    pin_five();
    ext_reset();
    drivers();
    conclude();
  end
endmodule : port_change_interrupt_pullups_test
